// ===== mailbox_defines.vh
`ifndef MAILBOX_DEFINES_VH
`define MAILBOX_DEFINES_VH

// word offsets inside the result area, relative to its head address
`define MB_FLAG_OFS      16'h0000
`define MB_TRIG_OFS      16'h0001
`define MB_ID_OFS        16'h0002
`define MB_CNT_OFS       16'h0003
`define MB_CHAR0_OFS     16'h0004
`define MB_CHARN_OFS     16'h0102

// flag word values
`define FLAG_RT_BUSY     16'h0001
`define FLAG_RT_DONE     16'h0000
`define FLAG_SQ_FREE     16'h0002
`define FLAG_SQ_FULL     16'h0003

// trigger word values
`define TRIG_WORD_ON     16'h0001
`define TRIG_WORD_OFF    16'h0000

// record limits
`define MAX_READER_CHARS 8'h20
`define ID_MIN           5'h01

// reset values
`define TRIG_RST         1'b0
`define LINK_ERR_RST     1'b0

// host poll interval
`define POLL_TIME_US     10
`define CLK_MHZ          100
`define POLL_CYC         (`POLL_TIME_US * `CLK_MHZ)

// fifo entry layout: {id, last, err, ovf, char}
`define FE_CHAR_LSB      0
`define FE_OVF_BIT       8
`define FE_ERR_BIT       9
`define FE_LAST_BIT      10
`define FE_ID_LSB        11
`define FE_WIDTH         16

`endif

// ===== result_fifo.v
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rp_r];

  always @(posedge mclk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      wp_r     <= {AW{1'b0}};
      rp_r     <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push)
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      cnt_r    <= cnt_nxt;
      in_ready <= (cnt_nxt != DEPTH[AW:0]);
    end
  end

endmodule
`default_nettype wire

// ===== msg_rom.v
`timescale 1ns/1ps
`default_nettype none

module msg_rom #(
  parameter [63:0] ERR_STR = 64'h0000004552524F52,
  parameter [3:0]  ERR_LEN = 4'h5
) (
  // selection
  input  wire       sel_ovf,
  input  wire [2:0] idx,
  // character out
  output wire [7:0] chr,
  output wire [3:0] len
);

  localparam [63:0] OVF_STR = 64'h000000004F564552;
  localparam [3:0]  OVF_LEN = 4'h4;

  wire [63:0] str  = sel_ovf ? OVF_STR : ERR_STR;
  wire [3:0]  slen = sel_ovf ? OVF_LEN : ERR_LEN;
  // characters are right-aligned, first character in the highest used byte
  wire [3:0]  pos  = slen - 4'h1 - {1'b0, idx};
  wire [5:0]  base = {pos[2:0], 3'b000};

  assign chr = str[base +: 8];
  assign len = slen;

endmodule
`default_nettype wire

// ===== scan_result_mailbox.v
// Function
// - one result area: flag, trigger, record
// - real-time: flag 0001 while writing record
// - real-time: flag 0000 when record complete
// - sequential: write only while flag 0002
// - sequential: flag 0003 after record written
// - host rewrites 0002; device waits for it
// - reader overflow delivers overflow string
// - trigger word 0001 on, 0000 off
// - setting disables trigger word use
// - reader id at +2, count at +3
// - ascii characters one per word from +4
// - read failure delivers error string
// - write only counted chars, at most 32
// - link error halts until test switch
// - both link ends use matching framing
`timescale 1ns/1ps
`default_nettype none
`include "mailbox_defines.vh"

module scan_result_mailbox #(
  parameter        POLL_CYC = `POLL_CYC,
  parameter        FDEPTH   = 8,
  parameter        FAW      = 3,
  parameter [63:0] ERR_STR  = 64'h0000004552524F52,
  parameter [3:0]  ERR_LEN  = 4'h5
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // settings
  input  wire        seq_mode,
  input  wire        trig_used,
  // operator
  input  wire        test_sw,
  output reg         link_err,
  // host memory word access
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire        mem_ack,
  input  wire        mem_err,
  input  wire [15:0] mem_rdata,
  // reader result stream
  input  wire        rd_valid,
  output wire        rd_ready,
  input  wire [4:0]  rd_id,
  input  wire [7:0]  rd_char,
  input  wire        rd_last,
  input  wire        rd_err,
  input  wire        rd_ovf,
  // reader trigger and status
  output reg         trig_on,
  output reg         rec_done,
  output reg         busy
);

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_TRIG  = 4'h1;
  localparam [3:0] S_FLAGR = 4'h2;
  localparam [3:0] S_BUSYW = 4'h3;
  localparam [3:0] S_CHAR  = 4'h4;
  localparam [3:0] S_MSG   = 4'h5;
  localparam [3:0] S_DRAIN = 4'h6;
  localparam [3:0] S_ID    = 4'h7;
  localparam [3:0] S_CNT   = 4'h8;
  localparam [3:0] S_DONE  = 4'h9;
  localparam [3:0] S_ERR   = 4'hA;

  localparam integer POLL_M1   = POLL_CYC - 1;
  localparam [15:0]  POLL_LAST = POLL_M1[15:0];

  reg  [3:0]  state_r;
  reg  [15:0] poll_r;
  reg  [4:0]  id_r;
  reg  [7:0]  cnt_r;
  reg  [2:0]  midx_r;
  reg         movf_r;
  reg         test_d_r;
  reg         trig_turn_r;
  reg         h_last_seen_n;

  wire                 f_valid;
  wire [`FE_WIDTH-1:0] f_data;
  wire [7:0]           m_chr;
  wire [3:0]           m_len;

  wire [7:0] h_char = f_data[`FE_CHAR_LSB +: 8];
  wire       h_ovf  = f_data[`FE_OVF_BIT];
  wire       h_err  = f_data[`FE_ERR_BIT];
  wire       h_last = f_data[`FE_LAST_BIT];
  wire [4:0] h_id   = f_data[`FE_ID_LSB +: 5];

  wire poll_due  = (poll_r == 16'h0000);
  wire test_rise = test_sw && !test_d_r;
  wire issue     = !mem_req;
  wire done_ok   = mem_req && mem_ack && !mem_err;
  wire ack_bad   = mem_req && mem_ack && mem_err;

  // outcome of a finished trigger poll
  wire trig_seen = (state_r == S_TRIG) && done_ok;
  wire trig_set  = trig_seen && (mem_rdata == `TRIG_WORD_ON);
  wire trig_clr  = trig_seen && (mem_rdata == `TRIG_WORD_OFF);

  // the reader holds back results while the fifo is full
  wire f_pop = f_valid && issue &&
               ((state_r == S_CHAR) || (state_r == S_DRAIN));

  result_fifo #(
    .WIDTH (`FE_WIDTH),
    .DEPTH (FDEPTH),
    .AW    (FAW)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (rd_valid),
    .in_ready  (rd_ready),
    .in_data   ({rd_id, rd_last, rd_err, rd_ovf, rd_char}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  msg_rom #(
    .ERR_STR (ERR_STR),
    .ERR_LEN (ERR_LEN)
  ) u_msg (
    .sel_ovf (movf_r),
    .idx     (midx_r),
    .chr     (m_chr),
    .len     (m_len)
  );

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_r     <= S_IDLE;
      poll_r      <= 16'h0000;
      id_r        <= `ID_MIN;
      cnt_r       <= 8'h00;
      midx_r      <= 3'h0;
      movf_r      <= 1'b0;
      test_d_r    <= 1'b0;
      trig_turn_r <= 1'b0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 16'h0000;
      mem_wdata   <= 16'h0000;
      rec_done    <= 1'b0;
      busy        <= 1'b0;
    end else begin
      test_d_r <= test_sw;
      rec_done <= 1'b0;
      if (!poll_due)
        poll_r <= poll_r - 16'h0001;
      if (mem_req && mem_ack)
        mem_req <= 1'b0;
      // any failed host access stops the link until the operator acts
      if (ack_bad) begin
        state_r  <= S_ERR;
        busy     <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            busy <= 1'b0;
            if (poll_due && trig_used && trig_turn_r) begin
              trig_turn_r <= 1'b0;
              mem_req     <= 1'b1;
              mem_we      <= 1'b0;
              mem_addr    <= `MB_TRIG_OFS;
              state_r     <= S_TRIG;
            end else if (f_valid && seq_mode && poll_due) begin
              trig_turn_r <= 1'b1;
              mem_req     <= 1'b1;
              mem_we      <= 1'b0;
              mem_addr    <= `MB_FLAG_OFS;
              state_r     <= S_FLAGR;
            end else if (f_valid && !seq_mode) begin
              trig_turn_r <= 1'b1;
              busy        <= 1'b1;
              cnt_r       <= 8'h00;
              mem_req     <= 1'b1;
              mem_we      <= 1'b1;
              mem_addr    <= `MB_FLAG_OFS;
              mem_wdata   <= `FLAG_RT_BUSY;
              state_r     <= S_BUSYW;
            end else if (poll_due) begin
              trig_turn_r <= 1'b1;
            end
          end
          S_TRIG: begin
            if (done_ok) begin
              poll_r  <= POLL_LAST;
              state_r <= S_IDLE;
            end
          end
          S_FLAGR: begin
            if (done_ok) begin
              if (mem_rdata == `FLAG_SQ_FREE) begin
                busy    <= 1'b1;
                cnt_r   <= 8'h00;
                state_r <= S_CHAR;
              end else begin
                poll_r  <= POLL_LAST;
                state_r <= S_IDLE;
              end
            end
          end
          S_BUSYW: begin
            if (done_ok)
              state_r <= S_CHAR;
          end
          S_CHAR: begin
            if (issue && f_valid) begin
              id_r <= h_id;
              if (h_err || h_ovf) begin
                // the whole record is replaced by the message string
                movf_r  <= h_ovf;
                midx_r  <= 3'h0;
                cnt_r   <= 8'h00;
                state_r <= S_MSG;
                if (!h_last)
                  trig_turn_r <= trig_turn_r;
              end else if (cnt_r < `MAX_READER_CHARS) begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= `MB_CHAR0_OFS + {8'h00, cnt_r};
                mem_wdata <= {8'h00, h_char};
                cnt_r     <= cnt_r + 8'h01;
                if (h_last)
                  state_r <= S_ID;
              end else if (h_last) begin
                state_r <= S_ID;
              end
            end
          end
          S_MSG: begin
            if (issue && !(mem_req && mem_ack)) begin
              if ({1'b0, midx_r} < m_len) begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= `MB_CHAR0_OFS + {13'h0000, midx_r};
                mem_wdata <= {8'h00, m_chr};
                midx_r    <= midx_r + 3'h1;
                cnt_r     <= cnt_r + 8'h01;
              end else begin
                if (h_last_seen_n)
                  state_r <= S_DRAIN;
                else
                  state_r <= S_ID;
              end
            end
          end
          S_DRAIN: begin
            if (issue && f_valid && h_last)
              state_r <= S_ID;
          end
          S_ID: begin
            if (issue && !(mem_req && mem_ack)) begin
              // characters first, header words next, flag word last
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= `MB_ID_OFS;
              mem_wdata <= {11'h000, id_r};
              state_r   <= S_CNT;
            end
          end
          S_CNT: begin
            // at least one idle cycle after each acknowledge before the next request
            if (issue) begin
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= `MB_CNT_OFS;
              mem_wdata <= {8'h00, cnt_r};
              state_r   <= S_DONE;
            end
          end
          S_DONE: begin
            if (issue && mem_addr == `MB_CNT_OFS) begin
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= `MB_FLAG_OFS;
              mem_wdata <= seq_mode ? `FLAG_SQ_FULL : `FLAG_RT_DONE;
            end else if (done_ok && mem_addr == `MB_FLAG_OFS) begin
              rec_done <= 1'b1;
              busy     <= 1'b0;
              poll_r   <= POLL_LAST;
              state_r  <= S_IDLE;
            end
          end
          S_ERR: begin
            // no request leaves while the link is halted
            mem_req <= 1'b0;
            if (test_rise) begin
              state_r <= S_IDLE;
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // a message record still owes the rest of its reader beats unless the
  // bad beat was itself the last one
  always @(posedge mclk) begin
    if (!rst_n)
      h_last_seen_n <= 1'b0;
    else if (state_r == S_CHAR && issue && f_valid && (h_err || h_ovf))
      h_last_seen_n <= !h_last;
  end

  // trigger follows the last polled trigger word; other values keep it
  always @(posedge mclk) begin
    if (!rst_n)
      trig_on <= `TRIG_RST;
    else if (!trig_used)
      trig_on <= 1'b0;
    else if (trig_set)
      trig_on <= 1'b1;
    else if (trig_clr)
      trig_on <= 1'b0;
  end

  // a failed access halts the link until the operator presses the test switch
  always @(posedge mclk) begin
    if (!rst_n)
      link_err <= `LINK_ERR_RST;
    else if (ack_bad)
      link_err <= 1'b1;
    else if (state_r == S_ERR && test_rise)
      link_err <= 1'b0;
  end

endmodule
`default_nettype wire

// ===== scan_result_mailbox_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module scan_result_mailbox_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // settings and status
  input wire logic        seq_mode,
  input wire logic        trig_used,
  input wire logic        link_err,
  input wire logic        trig_on,
  input wire logic        rec_done,
  // host memory port
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        mem_err,
  input wire logic [15:0] mem_rdata
);
  logic open_r;
  wire  flag_wr = mem_req && mem_we && mem_addr == 16'h0000;
  wire  ack_ok  = mem_ack && !mem_err;
  // record window: opened by busy flag write or free flag read
  always @(posedge mclk) begin
    if (!rst_n || link_err)
      open_r <= 1'b0;
    else if (ack_ok && flag_wr)
      open_r <= mem_wdata == 16'h0001;
    else if (ack_ok && !mem_we && mem_addr == 16'h0000)
      open_r <= mem_rdata == 16'h0002;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_wdata) && $stable(mem_we)) else $error("request moved");
  a_req_drop: assert property (mem_ack |=> !mem_req) else $error("request stuck");
  a_flag_codes: assert property (flag_wr |-> (seq_mode ?
    mem_wdata == 16'h0003 : mem_wdata <= 16'h0001)) else $error("bad flag value");
  a_write_window: assert property (mem_req && mem_we &&
    !(mem_addr == 16'h0000 && mem_wdata == 16'h0001) |-> open_r) else $error("write early");
  a_done_flag: assert property (rec_done |-> $past(mem_ack)
    && $past(flag_wr)) else $error("done without flag");
  a_addr_span: assert property (mem_req |-> mem_addr <= 16'h0023)
    else $error("address past 32 chars");
  a_id_count: assert property (mem_req && mem_we && mem_addr[15:1] == 15'h0001
    |-> mem_wdata inside {[16'h0001:16'h0020]}) else $error("id or count out of range");
  a_err_halt: assert property (mem_ack && mem_err |=> link_err)
    else $error("error not halted");
  a_halt_quiet: assert property (link_err && $past(link_err) |-> !mem_req)
    else $error("access while halted");
  a_trig_follow: assert property (ack_ok && trig_used && !mem_we &&
    mem_addr == 16'h0001 && mem_rdata == 16'h0001 |-> ##[1:2] trig_on) else $error("no trigger");
  a_trig_unused: assert property (!trig_used [*2] |-> !trig_on)
    else $error("trigger while unused");
  cover property (rec_done && seq_mode);
  cover property (rec_done && !seq_mode);
  cover property ($rose(link_err));
endmodule
bind scan_result_mailbox scan_result_mailbox_monitor u_mon (.mclk(mclk), .rst_n(rst_n),
  .seq_mode(seq_mode), .trig_used(trig_used), .link_err(link_err), .trig_on(trig_on),
  .rec_done(rec_done), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata));
`default_nettype wire

// ===== host_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // word access
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic            mem_ack,
  output logic            mem_err,
  output logic [15:0]     mem_rdata,
  // behaviour
  input wire logic [3:0]  lat,
  input wire logic        inj_err
);
  logic [15:0] mem [0:258];
  logic [3:0]  cnt;
  initial begin
    for (int i = 0; i < 259; i++)
      mem[i] = 16'hA5A5;
    mem_rdata = 16'h0000;
  end
  always @(posedge mclk) begin
    if (!rst_n || mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (cnt == lat) begin
      mem_ack <= 1'b1;
      // missing words and framing faults fail the access
      mem_err <= inj_err || mem_addr > 16'h0102;
      if (mem_we && !inj_err && mem_addr <= 16'h0102)
        mem[mem_addr[8:0]] <= mem_wdata;
      mem_rdata <= mem[mem_addr[8:0]];
    end else
      cnt <= cnt + 4'h1;
  end
endmodule
`default_nettype wire

// ===== test_scan_result_mailbox.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module test_scan_result_mailbox;
  logic        mclk, rst_n, seq_mode, trig_used, test_sw, inj_err, stalled;
  logic        rd_valid, rd_last, rd_err, rd_ovf, rd_ready;
  logic        link_err, mem_req, mem_we, mem_ack, mem_err, trig_on, rec_done, busy;
  logic [4:0]  rd_id;
  logic [7:0]  rd_char;
  logic [3:0]  lat;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  int          fails, checks, dones, cyc;
  scan_result_mailbox #(.POLL_CYC(8)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .seq_mode(seq_mode), .trig_used(trig_used), .test_sw(test_sw), .link_err(link_err),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_id(rd_id), .rd_char(rd_char), .rd_last(rd_last),
    .rd_err(rd_err), .rd_ovf(rd_ovf), .trig_on(trig_on), .rec_done(rec_done), .busy(busy));
  host_mem_model u_host (.mclk(mclk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata), .lat(lat), .inj_err(inj_err));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (rec_done === 1'b1) dones++;
    if (rd_valid && rd_ready === 1'b0) stalled = 1'b1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // holds the beat until an edge with rd_ready high
  task beat(input [4:0] id, input [7:0] c, input l, input e, input o);
    rd_valid = 1'b1; rd_id = id; rd_char = c; rd_last = l; rd_err = e; rd_ovf = o;
    while (rd_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
  endtask
  task send(input [4:0] id, input string s, input e, input o);
    for (int i = 0; i < s.len(); i++) beat(id, s[i], i == s.len() - 1, e, o);
    rd_valid = 1'b0;
  endtask
  task wait_done;
    int n;
    n = dones;
    for (int k = 0; k < 3000 && dones == n; k++) @(negedge mclk);
    `CHK("records", n + 1, dones)
  endtask
  task chk_rec(input [15:0] id, input [15:0] flag, input string s);
    `CHK("flag", flag, u_host.mem[0])
    `CHK("reader id", id, u_host.mem[2])
    `CHK("count", 16'(s.len()), u_host.mem[3])
    for (int i = 0; i < s.len(); i++) `CHK("char", {8'h00, s[i]}, u_host.mem[4 + i])
  endtask
  initial begin
    mclk = 1'b0; rst_n = 1'b0; seq_mode = 1'b0; trig_used = 1'b1; test_sw = 1'b0;
    inj_err = 1'b0; stalled = 1'b0; lat = 4'h0; rd_valid = 1'b0; rd_id = 5'h01;
    rd_char = 8'h00; rd_last = 1'b0; rd_err = 1'b0; rd_ovf = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    u_host.mem[0] = 16'h0001;
    u_host.mem[1] = 16'h0000;
    send(5'h0C, "KE12", 0, 0);
    wait_done();
    chk_rec(16'h000C, 16'h0000, "KE12");
    `CHK("spare word", 16'hA5A5, u_host.mem[8])
    send(5'h04, "?", 1, 0);
    wait_done();
    chk_rec(16'h0004, 16'h0000, "ERROR");
    send(5'h07, "?", 0, 1);
    wait_done();
    chk_rec(16'h0007, 16'h0000, "OVER");
    $display("test realtime done");
    lat = 4'h6;
    stalled = 1'b0;
    for (int i = 0; i < 34; i++) beat(5'h1F, 8'h41 + i[7:0], i == 33, 0, 0);
    rd_valid = 1'b0;
    wait_done();
    `CHK("fifo stall", 1'b1, stalled)
    `CHK("long count", 16'h0020, u_host.mem[3])
    `CHK("char 32", 16'h0060, u_host.mem[35])
    `CHK("spare word", 16'hA5A5, u_host.mem[36])
    lat = 4'h0;
    $display("test long done");
    seq_mode = 1'b1;
    u_host.mem[0] = 16'h0003;
    send(5'h02, "Z9", 0, 0);
    repeat (200) @(negedge mclk);
    `CHK("held id", 16'h001F, u_host.mem[2])
    u_host.mem[0] = 16'h0002;
    wait_done();
    chk_rec(16'h0002, 16'h0003, "Z9");
    seq_mode = 1'b0;
    $display("test sequential done");
    u_host.mem[1] = 16'h0001;
    repeat (100) @(negedge mclk);
    `CHK("trigger on", 1'b1, trig_on)
    u_host.mem[1] = 16'h0000;
    repeat (100) @(negedge mclk);
    `CHK("trigger off", 1'b0, trig_on)
    trig_used = 1'b0;
    u_host.mem[1] = 16'h0001;
    repeat (100) @(negedge mclk);
    `CHK("trigger unused", 1'b0, trig_on)
    u_host.mem[1] = 16'h0000;
    trig_used = 1'b1;
    $display("test trigger done");
    inj_err = 1'b1;
    send(5'h03, "Q", 0, 0);
    for (int k = 0; k < 500 && link_err !== 1'b1; k++) @(negedge mclk);
    inj_err = 1'b0;
    `CHK("link error", 1'b1, link_err)
    repeat (50) @(negedge mclk);
    `CHK("halted request", 1'b0, mem_req)
    test_sw = 1'b1;
    repeat (4) @(negedge mclk);
    test_sw = 1'b0;
    `CHK("link resumed", 1'b0, link_err)
    wait_done();
    chk_rec(16'h0003, 16'h0000, "Q");
    $display("test link done");
    report_and_stop();
  end
endmodule
`default_nettype wire
